// ### mpsm_carrier_model.sv
// behavioural carrier board: buttons, sensors, wake sources and main supply
`timescale 1ns/1ps
module mpsm_carrier_model #(
    parameter int unsigned HOLD_MIN = 7
) (
    input  wire logic                     clk,        // standby clock
    output logic [mpsm_pkg::NUM_IN-1:0]   pin_n,      // low-active lanes, pulled up when idle
    output logic                          supply_good // main power valid
);
    initial
    begin
        pin_n       = '1;
        supply_good = 1'b1;
    end

    // low pulse on one lane, never shorter than the qualifying hold
    task automatic press(input int idx, input int hold);
        int h;
        h = (hold < HOLD_MIN) ? HOLD_MIN : hold;
        fork
        begin
            pin_n[idx] <= 1'b0;
            repeat (h) @(posedge clk);
            pin_n[idx] <= 1'b1;
        end
        join_none
    endtask : press

    task automatic set_pin(input int idx, input logic v);
        pin_n[idx] <= v;
    endtask : set_pin

    task automatic set_supply(input logic v);
        supply_good <= v;
    endtask : set_supply
endmodule : mpsm_carrier_model

// ### mpsm_in_qual.sv
// two-stage synchroniser with stable-level qualifier and fall pulse
`timescale 1ns/1ps
module mpsm_in_qual #(
    parameter int unsigned QUAL_CYCLES = 1,
    parameter bit          RESET_LEVEL = 1'b1
) (
    input  wire logic clk,    // standby clock
    input  wire logic rst,    // async reset, active high
    input  wire logic pin_in, // raw pin level
    output logic      level,  // qualified level
    output logic      fall    // one-cycle pulse on qualified fall
);
    localparam int W = mpsm_pkg::QUAL_CNT_W;
    localparam logic [W-1:0] LAST = W'(QUAL_CYCLES - 1);

    logic         sync1_r;
    logic         sync2_r;
    logic         level_r;
    logic         fall_r;
    logic [W-1:0] cnt_r;

    wire differs = sync2_r != level_r;
    wire done    = cnt_r >= LAST;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_r <= RESET_LEVEL;
            sync2_r <= RESET_LEVEL;
            level_r <= RESET_LEVEL;
            fall_r  <= 1'b0;
            cnt_r   <= '0;
        end
        else
        begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            fall_r  <= differs && done && level_r;
            if (differs && done)
                level_r <= sync2_r;
            cnt_r   <= (differs && !done) ? cnt_r + W'(1) : '0;
        end
    end

    assign level = level_r;
    assign fall  = fall_r;

    chk_fall_after_level : assert property (@(posedge clk) disable iff (rst)
        fall |-> !level_r && $past(level_r))
        else $error("fall pulse without qualified high-to-low change");

endmodule : mpsm_in_qual

// ### mpsm_pkg.sv
// constants and types shared by the module power state manager
package mpsm_pkg;

    localparam int unsigned CLK_PERIOD_NS = 100;

    // least hold time of a carrier button, rounded up to cycles
    localparam int unsigned BTN_MIN_MS      = 16;
    localparam int unsigned BTN_QUAL_CYCLES =
        (BTN_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned QUAL_CNT_W      = 18;

    // suspend warning lead time before a low-power state
    localparam int unsigned WARN_US     = 10;
    localparam int unsigned WARN_CYCLES = (WARN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WARN_CNT_W  = 7;
    localparam logic [WARN_CNT_W-1:0] WARN_LAST = WARN_CNT_W'(WARN_CYCLES - 1);

    // carrier reset pulse width
    localparam int unsigned RST_PULSE_US     = 100;
    localparam int unsigned RST_PULSE_CYCLES =
        (RST_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W        = 10;
    localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RST_PULSE_CYCLES);

    // input qualifier lanes
    localparam int unsigned IN_PWR    = 0;
    localparam int unsigned IN_RST    = 1;
    localparam int unsigned IN_LID    = 2;
    localparam int unsigned IN_SLEEP  = 3;
    localparam int unsigned IN_PCIE   = 4;
    localparam int unsigned IN_GEN    = 5;
    localparam int unsigned IN_BAT    = 6;
    localparam int unsigned IN_OTEMP  = 7;
    localparam int unsigned IN_ALERT  = 8;
    localparam int unsigned IN_SUPPLY = 9;
    localparam int unsigned NUM_IN    = 10;

    typedef enum logic [2:0] {ST_ON, ST_WARN, ST_RAM, ST_DISK, ST_OFF} mpsm_state_t;
    typedef enum logic [1:0] {TGT_RAM, TGT_DISK, TGT_OFF} mpsm_target_t;

endpackage : mpsm_pkg

// ### mpsm_power_manager.sv
// power, reset and suspend-state sequencing toward the carrier board
//
// Overview of operation
// - power button falling edge leaves soft-off
// - reset button edge starts reset, never held
// - five causes drive carrier reset low
// - supply good high means good, low resets
// - suspend-imminent asserted before any low-power state except soft-off on processor thermal shutdown
// - suspend-to-RAM indicator low in that state
// - suspend-to-disk indicator low in that state
// - soft-off indicator low in soft-off
// - PCIe wake resumes from suspend-to-RAM or suspend-to-disk, not soft-off
// - general wake resumes from suspend-to-RAM or suspend-to-disk, not soft-off
// - battery low level reported as event
// - lid switch sampled, reported open or closed
// - sleep button reported, active in soft-off
// - low overtemp input means over-temperature
// - thermal trip low after processor thermal shutdown
// - management alert gives interrupt or wake
// - rapid-shutdown trigger ignored entirely
`timescale 1ns/1ps
module mpsm_power_manager #(
    parameter int unsigned BTN_QUAL_CYCLES = mpsm_pkg::BTN_QUAL_CYCLES
) (
    input  wire logic       CLOCK,                // standby clock, 10 MHz
    input  wire logic       SYS_RST,              // async reset, active high
    input  wire logic       POWER_BUTTON_N,       // power button, active low
    input  wire logic       RESET_BUTTON_N,       // reset button, active low
    input  wire logic       LID_SWITCH_N,         // lid closed when low
    input  wire logic       SLEEP_BUTTON_N,       // sleep button, active low
    input  wire logic       PCIE_WAKE_N,          // PCIe wake, active low
    input  wire logic       GENERAL_WAKE_N,       // general wake, active low
    input  wire logic       BATTERY_LOW_N,        // battery low, active low
    input  wire logic       OVERTEMP_IN_N,        // off-module sensor, active low
    input  wire logic       MGMT_BUS_ALERT_N,     // management bus alert, active low
    input  wire logic       SUPPLY_GOOD,          // main power valid, active high
    input  wire logic       RAPID_SHUTDOWN,       // unsupported trigger
    input  wire logic       MAIN_SUPPLY_LOW,      // main rail under minimum
    input  wire logic       WATCHDOG_TIMEOUT,     // watchdog expiry
    input  wire logic       SW_RESET_REQ,         // software reset request
    input  wire logic       SW_SLEEP_REQ,         // software sleep request
    input  wire logic [1:0] SW_SLEEP_TARGET,      // 0 ram, 1 disk, 2 soft-off
    input  wire logic       CPU_THERMAL_SHUTDOWN, // processor thermal shutdown
    output logic            CARRIER_RESET_OUT_N,  // carrier reset, active low
    output logic            SUSPEND_IMMINENT_N,   // suspend warning, active low
    output logic            SUSPEND_TO_RAM_N,     // suspend-to-RAM, active low
    output logic            SUSPEND_TO_DISK_N,    // suspend-to-disk, active low
    output logic            SOFT_OFF_N,           // soft-off, active low
    output logic            THERMAL_TRIP_OUT_N,   // thermal trip, active low
    output logic            LID_CLOSED,           // lid closed level
    output logic            OVERTEMP,             // over-temperature level
    output logic            BATTERY_LOW,          // battery low level
    output logic            BATTERY_LOW_EVENT,    // pulse on battery low onset
    output logic            POWER_BUTTON_EVENT,   // pulse, press while running
    output logic            SLEEP_BUTTON_EVENT,   // pulse, sleep press
    output logic            MGMT_SMI,             // pulse, alert while running
    output logic            WAKE_EVENT            // pulse, resume taken
);
    localparam int unsigned NI = mpsm_pkg::NUM_IN;
    localparam int unsigned RC = mpsm_pkg::RST_CNT_W;
    localparam int unsigned WC = mpsm_pkg::WARN_CNT_W;

    default clocking dclk @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    function automatic logic is_low(input mpsm_pkg::mpsm_state_t s);
        is_low = (s == mpsm_pkg::ST_RAM) || (s == mpsm_pkg::ST_DISK) ||
                 (s == mpsm_pkg::ST_OFF);
    endfunction : is_low

    function automatic logic is_running(input mpsm_pkg::mpsm_state_t s);
        is_running = (s == mpsm_pkg::ST_ON) || (s == mpsm_pkg::ST_WARN);
    endfunction : is_running

    // input qualification
    wire [NI-1:0] pin_vec = {SUPPLY_GOOD, MGMT_BUS_ALERT_N, OVERTEMP_IN_N, BATTERY_LOW_N,
                             GENERAL_WAKE_N, PCIE_WAKE_N, SLEEP_BUTTON_N, LID_SWITCH_N,
                             RESET_BUTTON_N, POWER_BUTTON_N};
    logic [NI-1:0] lvl;
    logic [NI-1:0] fall;

    genvar gi;
    generate
        for (gi = 0; gi < NI; gi++)
        begin : g_in
            // buttons and the lid switch need the long hold, the rest only synchronise
            mpsm_in_qual #(
                .QUAL_CYCLES (gi <= mpsm_pkg::IN_SLEEP ? BTN_QUAL_CYCLES : 1),
                .RESET_LEVEL (gi == mpsm_pkg::IN_SUPPLY ? 1'b0 : 1'b1)
            ) u_qual (
                .clk    (CLOCK),
                .rst    (SYS_RST),
                .pin_in (pin_vec[gi]),
                .level  (lvl[gi]),
                .fall   (fall[gi])
            );
        end
    endgenerate

    // RAPID_SHUTDOWN is deliberately left unconnected

    mpsm_pkg::mpsm_state_t  state_r;
    mpsm_pkg::mpsm_state_t  state_nxt;
    mpsm_pkg::mpsm_target_t tgt_r;
    logic [WC-1:0]          warn_cnt_r;
    logic [RC-1:0]          rst_cnt_r;
    logic [RC-1:0]          rst_cnt_nxt;
    logic                   trip_r;

    wire pwr_fall   = fall[mpsm_pkg::IN_PWR];
    wire rst_fall   = fall[mpsm_pkg::IN_RST];
    wire sleep_fall = fall[mpsm_pkg::IN_SLEEP];
    wire pcie_fall  = fall[mpsm_pkg::IN_PCIE];
    wire gen_fall   = fall[mpsm_pkg::IN_GEN];
    wire alert_fall = fall[mpsm_pkg::IN_ALERT];
    wire bat_fall   = fall[mpsm_pkg::IN_BAT];

    wire supply_ok  = lvl[mpsm_pkg::IN_SUPPLY] && !MAIN_SUPPLY_LOW;
    wire running    = is_running(state_r);
    wire in_low     = is_low(state_r);
    wire in_suspend = (state_r == mpsm_pkg::ST_RAM) || (state_r == mpsm_pkg::ST_DISK);
    wire tgt_valid  = SW_SLEEP_TARGET != 2'h3;
    wire sleep_go   = (state_r == mpsm_pkg::ST_ON) && SW_SLEEP_REQ && tgt_valid;
    wire warn_done  = (state_r == mpsm_pkg::ST_WARN) && (warn_cnt_r == mpsm_pkg::WARN_LAST);

    // resume sources; alert, sleep and power button stay live in soft-off
    wire wake_any   = in_low && (pwr_fall || sleep_fall || alert_fall ||
                      (in_suspend && (pcie_fall || gen_fall)));

    // reset causes; the button counts only on its edge, never its level
    wire rst_trig   = !supply_ok ||
                      ((state_r == mpsm_pkg::ST_ON) &&
                       (rst_fall || WATCHDOG_TIMEOUT || SW_RESET_REQ)) ||
                      (in_low && state_nxt == mpsm_pkg::ST_ON);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            mpsm_pkg::ST_ON:
                if (sleep_go)
                    state_nxt = mpsm_pkg::ST_WARN;
            mpsm_pkg::ST_WARN:
                if (warn_done)
                begin
                    case (tgt_r)
                        mpsm_pkg::TGT_RAM:  state_nxt = mpsm_pkg::ST_RAM;
                        mpsm_pkg::TGT_DISK: state_nxt = mpsm_pkg::ST_DISK;
                        default:            state_nxt = mpsm_pkg::ST_OFF;
                    endcase
                end
            mpsm_pkg::ST_RAM, mpsm_pkg::ST_DISK, mpsm_pkg::ST_OFF:
                if (wake_any)
                    state_nxt = mpsm_pkg::ST_ON;
            default:
                state_nxt = mpsm_pkg::ST_OFF;
        endcase
        // processor thermal shutdown drops straight to soft-off
        if (CPU_THERMAL_SHUTDOWN)
            state_nxt = mpsm_pkg::ST_OFF;
    end

    assign rst_cnt_nxt = rst_trig ? mpsm_pkg::RST_LOAD :
                         (rst_cnt_r != '0) ? rst_cnt_r - RC'(1) : '0;

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_r    <= mpsm_pkg::ST_OFF;
            tgt_r      <= mpsm_pkg::TGT_OFF;
            warn_cnt_r <= '0;
            rst_cnt_r  <= '0;
            trip_r     <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            if (sleep_go)
                tgt_r  <= mpsm_pkg::mpsm_target_t'(SW_SLEEP_TARGET);
            warn_cnt_r <= (state_r == mpsm_pkg::ST_WARN) ? warn_cnt_r + WC'(1) : '0;
            rst_cnt_r  <= rst_cnt_nxt;
            // set wins over the power-button clear
            trip_r     <= CPU_THERMAL_SHUTDOWN ||
                          (trip_r && !(pwr_fall && state_r == mpsm_pkg::ST_OFF));
        end
    end

    // registered pin outputs, all but the thermal trip derived from next state
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            CARRIER_RESET_OUT_N <= 1'b0;
            SUSPEND_IMMINENT_N  <= 1'b0;
            SUSPEND_TO_RAM_N    <= 1'b0;
            SUSPEND_TO_DISK_N   <= 1'b0;
            SOFT_OFF_N          <= 1'b0;
            THERMAL_TRIP_OUT_N  <= 1'b1;
        end
        else
        begin
            CARRIER_RESET_OUT_N <= is_running(state_nxt) && (rst_cnt_nxt == '0);
            SUSPEND_IMMINENT_N  <= is_running(state_nxt) &&
                                   (state_nxt != mpsm_pkg::ST_WARN);
            SUSPEND_TO_RAM_N    <= !is_low(state_nxt);
            SUSPEND_TO_DISK_N   <= !((state_nxt == mpsm_pkg::ST_DISK) ||
                                     (state_nxt == mpsm_pkg::ST_OFF));
            SOFT_OFF_N          <= state_nxt != mpsm_pkg::ST_OFF;
            THERMAL_TRIP_OUT_N  <= !(CPU_THERMAL_SHUTDOWN || (trip_r &&
                                   !(pwr_fall && state_r == mpsm_pkg::ST_OFF)));
        end
    end

    // status levels and event pulses toward power management software
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            LID_CLOSED         <= 1'b0;
            OVERTEMP           <= 1'b0;
            BATTERY_LOW        <= 1'b0;
            BATTERY_LOW_EVENT  <= 1'b0;
            POWER_BUTTON_EVENT <= 1'b0;
            SLEEP_BUTTON_EVENT <= 1'b0;
            MGMT_SMI           <= 1'b0;
            WAKE_EVENT         <= 1'b0;
        end
        else
        begin
            LID_CLOSED         <= !lvl[mpsm_pkg::IN_LID];
            OVERTEMP           <= !lvl[mpsm_pkg::IN_OTEMP];
            BATTERY_LOW        <= !lvl[mpsm_pkg::IN_BAT];
            BATTERY_LOW_EVENT  <= bat_fall;
            POWER_BUTTON_EVENT <= running && pwr_fall;
            SLEEP_BUTTON_EVENT <= sleep_fall;
            MGMT_SMI           <= running && alert_fall;
            WAKE_EVENT         <= wake_any && !CPU_THERMAL_SHUTDOWN;
        end
    end

    // checks

    sequence warn_hold;
        !SUSPEND_IMMINENT_N && SUSPEND_TO_RAM_N && CARRIER_RESET_OUT_N;
    endsequence

    sequence resumed;
        state_r == mpsm_pkg::ST_ON ##0 !CARRIER_RESET_OUT_N;
    endsequence

    chk_warn_before_sleep : assert property (
        (sleep_go && !CPU_THERMAL_SHUTDOWN && supply_ok && rst_cnt_r == '0) |=> warn_hold [*8])
        else $error("suspend warning not held before low-power entry");

    chk_ram_after_warn : assert property (
        $fell(SUSPEND_TO_RAM_N) |-> $past(!SUSPEND_IMMINENT_N) || $past(CPU_THERMAL_SHUTDOWN)
                                    || $past(state_r) == mpsm_pkg::ST_WARN)
        else $error("low-power indicator without prior warning");

    chk_ram_level : assert property (
        (state_r == mpsm_pkg::ST_RAM) |-> !SUSPEND_TO_RAM_N && SUSPEND_TO_DISK_N && SOFT_OFF_N)
        else $error("suspend-to-RAM indicators wrong");

    chk_disk_level : assert property (
        (state_r == mpsm_pkg::ST_DISK) |-> !SUSPEND_TO_DISK_N && SOFT_OFF_N)
        else $error("suspend-to-disk indicator wrong");

    chk_off_level : assert property (
        (state_r == mpsm_pkg::ST_OFF) |-> !SOFT_OFF_N && !SUSPEND_TO_DISK_N)
        else $error("soft-off indicator not asserted");

    chk_power_wake : assert property (
        (state_r == mpsm_pkg::ST_OFF && pwr_fall && !CPU_THERMAL_SHUTDOWN) |=> resumed)
        else $error("power button did not leave soft-off");

    chk_pcie_wake : assert property (
        (state_r == mpsm_pkg::ST_RAM && pcie_fall && !CPU_THERMAL_SHUTDOWN) |=> resumed)
        else $error("PCIe wake did not resume");

    chk_general_wake : assert property (
        (state_r == mpsm_pkg::ST_DISK && gen_fall && !CPU_THERMAL_SHUTDOWN) |=> resumed)
        else $error("general wake did not resume");

    chk_supply_reset : assert property (
        !supply_ok |=> !CARRIER_RESET_OUT_N)
        else $error("carrier reset not driven with bad supply");

    chk_button_reset : assert property (
        (state_r == mpsm_pkg::ST_ON && rst_fall && !sleep_go && !CPU_THERMAL_SHUTDOWN)
        |=> !CARRIER_RESET_OUT_N ##0 rst_cnt_r == mpsm_pkg::RST_LOAD)
        else $error("reset button edge did not start reset");

    chk_reset_released : assert property (
        (state_r == mpsm_pkg::ST_ON && rst_cnt_r == RC'(1) && !rst_trig && !sleep_go &&
         !CPU_THERMAL_SHUTDOWN) |=> CARRIER_RESET_OUT_N)
        else $error("carrier reset held past its pulse");

    chk_reset_bound : assert property (
        (state_r == mpsm_pkg::ST_ON && !lvl[mpsm_pkg::IN_RST] && rst_cnt_r <= RC'(1) &&
         supply_ok && !rst_fall && !WATCHDOG_TIMEOUT && !SW_RESET_REQ && !sleep_go &&
         !CPU_THERMAL_SHUTDOWN) |=> CARRIER_RESET_OUT_N)
        else $error("carrier reset kept while reset button stays low");

    chk_trip_out : assert property (
        CPU_THERMAL_SHUTDOWN |=> !THERMAL_TRIP_OUT_N ##0 state_r == mpsm_pkg::ST_OFF
                                 ##1 !THERMAL_TRIP_OUT_N)
        else $error("thermal trip not latched");

    chk_alert_smi : assert property (
        (running && alert_fall) |=> MGMT_SMI ##1 !MGMT_SMI)
        else $error("management alert did not raise one interrupt pulse");

    chk_sleep_report : assert property (
        sleep_fall |=> SLEEP_BUTTON_EVENT)
        else $error("sleep button not reported");

    chk_status_levels : assert property (
        ##1 (LID_CLOSED == !$past(lvl[mpsm_pkg::IN_LID])) &&
            (OVERTEMP == !$past(lvl[mpsm_pkg::IN_OTEMP])) &&
            (BATTERY_LOW == !$past(lvl[mpsm_pkg::IN_BAT])))
        else $error("status level does not follow qualified input");

endmodule : mpsm_power_manager

// ### tb_top.sv
// self-checking testbench for the module power state manager
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned Q = 4;
    localparam logic [4:0] E_WAKE = 5'h10, E_SMI = 5'h08, E_SLP = 5'h04, E_PWR = 5'h02;
    logic CLOCK = 1'b0, RAPID_SHUTDOWN, supply_good, SYS_RST = 1'b1, MAIN_SUPPLY_LOW = 1'b0;
    logic WATCHDOG_TIMEOUT = 1'b0, SW_RESET_REQ = 1'b0, SW_SLEEP_REQ = 1'b0;
    logic CPU_THERMAL_SHUTDOWN = 1'b0;
    logic [1:0] SW_SLEEP_TARGET = 2'h0;
    logic [mpsm_pkg::NUM_IN-1:0] pin_n;
    logic rst_n, imm_n, ram_n, disk_n, off_n, trip_n, lid_c, otemp, batl;
    logic [4:0] ev;
    logic [5:0] ind;
    logic [2:0] lv;
    logic [4:0] exp_q[$];
    int n_mismatch = 0, checks_done = 0, seed = 32'h8300;
    assign ind = {rst_n, imm_n, ram_n, disk_n, off_n, trip_n};
    assign lv = {lid_c, otemp, batl};

    mpsm_power_manager #(.BTN_QUAL_CYCLES(Q)) u_dut (
        .CLOCK(CLOCK), .SYS_RST(SYS_RST), .POWER_BUTTON_N(pin_n[mpsm_pkg::IN_PWR]),
        .RESET_BUTTON_N(pin_n[mpsm_pkg::IN_RST]), .LID_SWITCH_N(pin_n[mpsm_pkg::IN_LID]),
        .SLEEP_BUTTON_N(pin_n[mpsm_pkg::IN_SLEEP]), .PCIE_WAKE_N(pin_n[mpsm_pkg::IN_PCIE]),
        .GENERAL_WAKE_N(pin_n[mpsm_pkg::IN_GEN]), .BATTERY_LOW_N(pin_n[mpsm_pkg::IN_BAT]),
        .OVERTEMP_IN_N(pin_n[mpsm_pkg::IN_OTEMP]), .MGMT_BUS_ALERT_N(pin_n[mpsm_pkg::IN_ALERT]),
        .SUPPLY_GOOD(supply_good), .RAPID_SHUTDOWN(RAPID_SHUTDOWN),
        .MAIN_SUPPLY_LOW(MAIN_SUPPLY_LOW), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
        .SW_RESET_REQ(SW_RESET_REQ), .SW_SLEEP_REQ(SW_SLEEP_REQ),
        .SW_SLEEP_TARGET(SW_SLEEP_TARGET), .CPU_THERMAL_SHUTDOWN(CPU_THERMAL_SHUTDOWN),
        .CARRIER_RESET_OUT_N(rst_n), .SUSPEND_IMMINENT_N(imm_n), .SUSPEND_TO_RAM_N(ram_n),
        .SUSPEND_TO_DISK_N(disk_n), .SOFT_OFF_N(off_n), .THERMAL_TRIP_OUT_N(trip_n),
        .LID_CLOSED(lid_c), .OVERTEMP(otemp), .BATTERY_LOW(batl), .BATTERY_LOW_EVENT(ev[0]),
        .POWER_BUTTON_EVENT(ev[1]), .SLEEP_BUTTON_EVENT(ev[2]), .MGMT_SMI(ev[3]),
        .WAKE_EVENT(ev[4]));
    mpsm_carrier_model #(.HOLD_MIN(Q + 3)) u_car (
        .clk(CLOCK), .pin_n(pin_n), .supply_good(supply_good));

    initial
    begin
        forever #50 CLOCK = ~CLOCK;
    end

    // trigger input must change nothing
    always @(posedge CLOCK) RAPID_SHUTDOWN <= 1'($random(seed));

    task automatic fail(input string msg);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask : fail
    task automatic chk_ind(input logic [5:0] e, input string what);
        checks_done++;
        if (ind !== e) fail($sformatf("%s: indicators %b, expected %b", what, ind, e));
    endtask : chk_ind
    task automatic chk_bit(input logic got, input logic e, input string what);
        checks_done++;
        if (got !== e) fail(what);
    endtask : chk_bit
    task automatic chk_ev(input logic [4:0] got, input logic [4:0] e);
        checks_done++;
        if (got !== e) fail($sformatf("event %b, expected %b", got, e));
    endtask : chk_ev

    // every event pulse takes the oldest expectation
    always @(negedge CLOCK)
        if (ev !== 5'h00)
            chk_ev(ev, exp_q.size() ? exp_q.pop_front() : 5'h00);

    // wait for carrier reset, then time how long it stays low
    task automatic rst_window(input int extra);
        int n;
        n = 0;
        while (rst_n !== 1'b0 && n++ < 20) @(negedge CLOCK);
        n = 0;
        while (rst_n === 1'b0 && n < 1200) @(negedge CLOCK) n++;
        chk_bit(n >= 998 && n <= 1003 + extra, 1'b1, "carrier reset width");
    endtask : rst_window

    task automatic go_sleep(input logic [1:0] tgt, input logic [5:0] e);
        logic [5:0] w;
        w = (tgt == 2'h3) ? 6'b111111 : 6'b101111;
        @(posedge CLOCK);
        SW_SLEEP_REQ    <= 1'b1;
        SW_SLEEP_TARGET <= tgt;
        @(posedge CLOCK);
        SW_SLEEP_REQ <= 1'b0;
        @(posedge CLOCK);
        @(negedge CLOCK);
        chk_ind(w, "warning");
        repeat (98) @(negedge CLOCK);
        chk_ind(w, "warning lead");
        @(negedge CLOCK);
        chk_ind(e, "suspend state");
    endtask : go_sleep

    task automatic wake(input int idx);
        int n;
        n = 0;
        exp_q.push_back(E_WAKE);
        @(posedge CLOCK);
        u_car.press(idx, Q + 3 + ($random(seed) & 7));
        while (ram_n !== 1'b1 && n++ < 40) @(negedge CLOCK);
        rst_window(0);
        chk_ind(6'b111111, "running");
    endtask : wake

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (40000) @(posedge CLOCK);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        int wk[3] = '{mpsm_pkg::IN_PCIE, mpsm_pkg::IN_GEN, mpsm_pkg::IN_ALERT};
        int pl[3] = '{mpsm_pkg::IN_PWR, mpsm_pkg::IN_SLEEP, mpsm_pkg::IN_ALERT};
        int ll[3] = '{mpsm_pkg::IN_BAT, mpsm_pkg::IN_OTEMP, mpsm_pkg::IN_LID};
        logic [4:0] ex[3] = '{E_PWR, E_SLP, E_SMI};
        logic [5:0] sx[4] = '{6'b000111, 6'b000011, 6'b000001, 6'b111111};
        @(negedge CLOCK);
        chk_ind(6'b000001, "in reset");
        repeat (2) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        repeat (3) @(posedge CLOCK);
        wake(mpsm_pkg::IN_PWR);
        for (int i = 0; i < 4; i++)
        begin
            go_sleep(2'(i), sx[i]);
            if (i < 3) wake(wk[i]);
        end
        for (int i = 0; i < 3; i++)
        begin
            exp_q.push_back(ex[i]);
            @(posedge CLOCK);
            u_car.press(pl[i], Q + 3);
            repeat (Q + 20) @(posedge CLOCK);
        end
        for (int i = 0; i < 3; i++)
        begin
            if (i == 0) exp_q.push_back(5'h01);
            @(posedge CLOCK);
            u_car.set_pin(ll[i], 1'b0);
            repeat (Q + 6) @(negedge CLOCK);
            chk_bit(lv[i], 1'b1, "status level set");
            @(posedge CLOCK);
            u_car.set_pin(ll[i], 1'b1);
            repeat (Q + 6) @(negedge CLOCK);
            chk_bit(lv[i], 1'b0, "status level clear");
        end
        for (int i = 0; i < 5; i++)
        begin
            @(posedge CLOCK);
            case (i)
                0: u_car.press(mpsm_pkg::IN_RST, 1500);
                1: WATCHDOG_TIMEOUT <= 1'b1;
                2: SW_RESET_REQ <= 1'b1;
                3: u_car.set_supply(1'b0);
                default: MAIN_SUPPLY_LOW <= 1'b1;
            endcase
            @(posedge CLOCK);
            {WATCHDOG_TIMEOUT, SW_RESET_REQ, MAIN_SUPPLY_LOW} <= 3'b000;
            repeat (2) @(posedge CLOCK);
            u_car.set_supply(1'b1);
            rst_window(8);
            chk_ind(6'b111111, "after reset cause");
        end
        @(posedge CLOCK);
        CPU_THERMAL_SHUTDOWN <= 1'b1;
        @(posedge CLOCK);
        CPU_THERMAL_SHUTDOWN <= 1'b0;
        @(posedge CLOCK);
        @(negedge CLOCK);
        chk_ind(6'b000000, "thermal trip");
        repeat (3) @(posedge CLOCK);
        wake(mpsm_pkg::IN_PWR);
        chk_bit(exp_q.size() == 0, 1'b1, "events missing");
        conclude();
    end
endmodule : tb_top
